// ---- fspl_pkg.sv ----
// shared constants, opcodes and types for the sector protection lock block
// What this block does
// - one volatile lock guards all persistent sector bits; 0 blocks, 1 permits change
// - the lock clear command only ever clears the lock to 0
// - persistent mode sets lock to 1 at reset; no command sets it again
// - software reset leaves the lock untouched
// - password mode clears lock at reset; only a good unlock sets it
// - sector unprotected only when persistent and volatile bits are both 1
// - volatile bits return to unprotected on any reset; persistent bits kept
// - full 64-bit compare; mismatch keeps lock, sets program error, holds busy
// - any password valid; ships all ones; programming only clears bits
// - in password mode password read and program are silently ignored
// - after a mismatch no unlock is accepted for 100 us, busy held meanwhile
// - matching password skips the delay and leaves busy clear
// - every command outside continuation mode opens with an 8-bit instruction on the serial input
// - addresses are 24 or 32 bits by configuration
// - the instruction fixes lane width of all later phases
// - msb first; address high byte first; data low address first, incrementing
// - continuation mode bits make the next frame omit the instruction
// - reads may insert dummy clocks before the first data bit
// - while busy, array reads are ignored and only a few commands taken
// - writes rejected when chip select rises off an 8-bit boundary
// - persistent program or erase fails while the lock is 0
// - mode field 11 none, 10 persistent, 01 password, 00 fails
package fspl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_UNLOCK_US   = 100;
  localparam int UNLOCK_CYC    = T_UNLOCK_US * 1000 / CLK_PERIOD_NS;
  localparam int T_PROG_US     = 1;
  localparam int PROG_CYC      = T_PROG_US * 1000 / CLK_PERIOD_NS;
  localparam int DUMMY_CYC     = 8;
  localparam int SECT_W        = 8;
  localparam int SECT_LSB      = 16;
  localparam int CNT_W         = 20;
  localparam int SR_WIP        = 0;
  localparam int SR_PERR       = 6;

  localparam logic [7:0]  OP_READ       = 8'h03;
  localparam logic [7:0]  OP_FAST       = 8'h0b;
  localparam logic [7:0]  OP_DOR        = 8'h3b;
  localparam logic [7:0]  OP_QOR        = 8'h6b;
  localparam logic [7:0]  OP_QIOR       = 8'heb;
  localparam logic [7:0]  OP_RDSR       = 8'h05;
  localparam logic [7:0]  OP_CLSR       = 8'h30;
  localparam logic [7:0]  OP_SWRST      = 8'hf0;
  localparam logic [7:0]  OP_LOCK_RD    = 8'ha7;
  localparam logic [7:0]  OP_LOCK_CLR   = 8'ha6;
  localparam logic [7:0]  OP_CFG_RD     = 8'h2b;
  localparam logic [7:0]  OP_CFG_PROG   = 8'h2f;
  localparam logic [7:0]  OP_PERS_RD    = 8'he2;
  localparam logic [7:0]  OP_PERS_PROG  = 8'he3;
  localparam logic [7:0]  OP_PERS_ERASE = 8'he4;
  localparam logic [7:0]  OP_VOL_RD     = 8'he0;
  localparam logic [7:0]  OP_VOL_WR     = 8'he1;
  localparam logic [7:0]  OP_PWD_RD     = 8'he7;
  localparam logic [7:0]  OP_PWD_PROG   = 8'he8;
  localparam logic [7:0]  OP_PWD_UNLOCK = 8'he9;

  localparam logic [1:0]  MODE_NONE = 2'b11;
  localparam logic [1:0]  MODE_PERS = 2'b10;
  localparam logic [1:0]  MODE_PWD  = 2'b01;
  localparam logic [1:0]  MODE_BAD  = 2'b00;
  localparam int          MODE_LSB  = 1;
  localparam logic [3:0]  CONT_NIB  = 4'ha;
  localparam logic [7:0]  BYTE_ONES = 8'hff;
  localparam logic [63:0] PWD_SHIP  = 64'hffff_ffff_ffff_ffff;
  localparam logic [5:0]  PIN_RST   = 6'h20;

  typedef enum logic [1:0] {
    LN_1 = 2'b00,
    LN_2 = 2'b01,
    LN_4 = 2'b10
  } fspl_lane_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_CMD   = 4'b0001,
    ST_ADDR  = 4'b0010,
    ST_MODE  = 4'b0011,
    ST_DUMMY = 4'b0100,
    ST_DIN   = 4'b0101,
    ST_DOUT  = 4'b0110,
    ST_WAIT  = 4'b0111,
    ST_IGN   = 4'b1000
  } fspl_state_t;

  typedef struct packed {
    logic       ok;
    logic       addr;
    logic       mode;
    logic       din;
    logic       dout;
    logic       arr;
    logic       dum;
    fspl_lane_t al;
    fspl_lane_t dl;
    logic [3:0] dlen;
  } fspl_dec_t;
endpackage

// ---- fspl_secmem.sv ----
// per-sector persistent and volatile protection bit store
`timescale 1ns/100ps
module fspl_secmem #(
  parameter int SECT_W = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_factory,
  input  wire logic [SECT_W-1:0] i_sect,
  input  wire logic              i_pers_clr,
  input  wire logic              i_pers_erase,
  input  wire logic              i_vol_we,
  input  wire logic              i_vol_val,
  input  wire logic              i_vol_reset,
  output logic                   o_pers,
  output logic                   o_vol
);
  localparam int N = 1 << SECT_W;
  logic [N-1:0] pers_q;
  logic [N-1:0] vol_q;

  // non-volatile: survives every reset
  always_ff @(posedge i_clk) begin
    if (i_factory || i_pers_erase) begin
      pers_q <= '1;
    end else if (i_pers_clr) begin
      pers_q[i_sect] <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      vol_q <= '1;
    end else if (i_vol_reset) begin
      vol_q <= '1;
    end else if (i_vol_we) begin
      vol_q[i_sect] <= i_vol_val;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pers <= 1'b0;
      o_vol  <= 1'b0;
    end else begin
      o_pers <= pers_q[i_sect];
      o_vol  <= vol_q[i_sect];
    end
  end
endmodule

// ---- fspl_lock.sv ----
// serial command front end and sector protection lock logic
`timescale 1ns/100ps
module fspl_lock #(
  parameter int UNLOCK_CYC = fspl_pkg::UNLOCK_CYC,
  parameter int PROG_CYC   = fspl_pkg::PROG_CYC,
  parameter int DUMMY_CYC  = fspl_pkg::DUMMY_CYC,
  parameter int SECT_W     = fspl_pkg::SECT_W
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_factory_init,
  input  wire logic        i_addr32,
  input  wire logic        i_sck,
  input  wire logic        i_cs_n,
  input  wire logic [3:0]  i_io,
  output logic      [3:0]  o_io,
  output logic      [3:0]  o_io_oe_n,
  output logic             o_arr_rd,
  output logic      [31:0] o_arr_addr,
  input  wire logic [7:0]  i_arr_data,
  output logic             o_lock,
  output logic             o_wip,
  output logic             o_perr,
  output logic      [1:0]  o_mode,
  output logic             o_sect_unprot
);
  import fspl_pkg::*;

  function automatic fspl_dec_t decode(input logic [7:0] c);
    fspl_dec_t d;
    d = fspl_dec_t'('0);
    d.dlen = 4'h1;
    d.ok = 1'b1;
    case (c)
      OP_READ: begin
        d.addr = 1'b1; d.dout = 1'b1; d.arr = 1'b1;
      end
      OP_FAST, OP_DOR, OP_QOR: begin
        d.addr = 1'b1; d.dout = 1'b1; d.arr = 1'b1; d.dum = 1'b1;
        d.dl = (c == OP_DOR) ? LN_2 : (c == OP_QOR) ? LN_4 : LN_1;
      end
      OP_QIOR: begin
        d.addr = 1'b1; d.mode = 1'b1; d.dout = 1'b1; d.arr = 1'b1;
        d.dum = 1'b1; d.al = LN_4; d.dl = LN_4;
      end
      OP_RDSR, OP_LOCK_RD, OP_CFG_RD, OP_PWD_RD: d.dout = 1'b1;
      OP_PERS_RD, OP_VOL_RD: begin
        d.addr = 1'b1; d.dout = 1'b1;
      end
      OP_PERS_PROG: d.addr = 1'b1;
      OP_VOL_WR: begin
        d.addr = 1'b1; d.din = 1'b1;
      end
      OP_CFG_PROG: d.din = 1'b1;
      OP_PWD_PROG, OP_PWD_UNLOCK: begin
        d.din = 1'b1; d.dlen = 4'h8;
      end
      OP_LOCK_CLR, OP_CLSR, OP_SWRST, OP_PERS_ERASE: d.ok = 1'b1;
      default: d.ok = 1'b0;
    endcase
    return d;
  endfunction

  // msb-first shift of one lane group
  function automatic logic [63:0] shift_in(input logic [63:0] s,
                                           input logic [3:0] io,
                                           input fspl_lane_t ln);
    case (ln)
      LN_2:    return {s[61:0], io[1:0]};
      LN_4:    return {s[59:0], io};
      default: return {s[62:0], io[0]};
    endcase
  endfunction

  function automatic logic [3:0] out_map(input logic [7:0] w,
                                         input fspl_lane_t ln);
    case (ln)
      LN_2:    return {2'b00, w[7:6]};
      LN_4:    return w[7:4];
      default: return {2'b00, w[7], 1'b0};
    endcase
  endfunction

  function automatic logic [2:0] lane_bits(input fspl_lane_t ln);
    return 3'(4'd1 << ln);
  endfunction

  // pins: two flops before any use
  logic [5:0]  pin_s1_q;
  logic [5:0]  pin_s2_q;
  logic        cs_d_q;
  logic        sck_d_q;
  fspl_state_t st_q;
  fspl_state_t st_d;
  logic [5:0]  cnt_q;
  logic [2:0]  bits_q;
  logic [63:0] sh_q;
  logic [7:0]  cmd_q;
  logic [31:0] addr_q;
  logic        cont_q;
  logic [3:0]  din_cnt_q;
  logic [7:0]  osh_q;
  logic [2:0]  ocnt_q;
  logic [2:0]  bidx_q;
  logic        init_q;
  logic        lock_d;
  logic        perr_d;
  logic        wip_d;
  logic [CNT_W-1:0] busy_q;
  logic [CNT_W-1:0] busy_d;
  logic [CNT_W-1:0] ulk_q;
  logic [CNT_W-1:0] ulk_d;
  logic [1:0]  mode_d;
  logic [63:0] pwd_q;
  logic [63:0] pwd_d;
  logic        pclr;
  logic        perase;
  logic        vwe;
  logic        vrst;
  logic        pers_bit;
  logic        vol_bit;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_q <= PIN_RST;
      pin_s2_q <= PIN_RST;
      cs_d_q   <= 1'b1;
      sck_d_q  <= 1'b0;
    end else begin
      pin_s1_q <= {i_cs_n, i_sck, i_io};
      pin_s2_q <= pin_s1_q;
      cs_d_q   <= pin_s2_q[5];
      sck_d_q  <= pin_s2_q[4];
    end
  end

  wire       cs_n_s    = pin_s2_q[5];
  wire [3:0] io_s      = pin_s2_q[3:0];
  wire       rise_w    = pin_s2_q[4] & ~sck_d_q;
  wire       fall_w    = ~pin_s2_q[4] & sck_d_q;
  wire       cs_fall_w = ~cs_n_s & cs_d_q;
  wire       cs_rise_w = cs_n_s & ~cs_d_q;

  // instruction decoded while its last bit arrives
  wire [7:0] cmd_in_w = {sh_q[6:0], io_s[0]};
  wire [7:0] dcmd_w   = (st_q == ST_CMD) ? cmd_in_w : cmd_q;
  fspl_dec_t dc;
  assign dc = decode(dcmd_w);
  wire sub_w = (dcmd_w == OP_RDSR) | (dcmd_w == OP_CLSR) |
               (dcmd_w == OP_SWRST);
  wire pwd_blk_w = (o_mode == MODE_PWD) &
                   ((dcmd_w == OP_PWD_RD) | (dcmd_w == OP_PWD_PROG));
  wire acc_w = dc.ok & (~o_wip | sub_w) & ~pwd_blk_w;

  fspl_lane_t ph_lane_w;
  assign ph_lane_w = (st_q == ST_CMD) ? LN_1 :
                     (st_q == ST_ADDR || st_q == ST_MODE) ? dc.al : dc.dl;
  wire [5:0] a_edges_w = (i_addr32 ? 6'd32 : 6'd24) >> ph_lane_w;
  wire [5:0] b_edges_w = 6'd8 >> ph_lane_w;
  wire [5:0] dum_w     = dc.dum ? 6'(DUMMY_CYC) : 6'd0;
  wire [5:0] last_w    = (st_q == ST_ADDR)  ? a_edges_w - 6'd1 :
                         (st_q == ST_DUMMY) ? dum_w - 6'd1 :
                         b_edges_w - 6'd1;
  wire        end_w   = rise_w & (cnt_q == last_w);
  wire [63:0] sh_nx_w = shift_in(sh_q, io_s, ph_lane_w);
  wire [31:0] addr_nx_w = i_addr32 ? sh_nx_w[31:0]
                                   : {8'h00, sh_nx_w[23:0]};

  fspl_state_t nx_dat;
  fspl_state_t nx_dum;
  fspl_state_t nx_mod;
  fspl_state_t nx_adr;
  assign nx_dat = dc.din ? ST_DIN : dc.dout ? ST_DOUT : ST_WAIT;
  assign nx_dum = (dum_w != 6'd0) ? ST_DUMMY : nx_dat;
  assign nx_mod = dc.mode ? ST_MODE : nx_dum;
  assign nx_adr = dc.addr ? ST_ADDR : nx_mod;

  always_comb begin
    st_d = st_q;
    if (cs_n_s) begin
      st_d = ST_IDLE;
    end else if (cs_fall_w) begin
      st_d = !cont_q ? ST_CMD : o_wip ? ST_IGN : ST_ADDR;
    end else if (end_w) begin
      case (st_q)
        ST_CMD:   st_d = acc_w ? nx_adr : ST_IGN;
        ST_ADDR:  st_d = nx_mod;
        ST_MODE:  st_d = nx_dum;
        ST_DUMMY: st_d = nx_dat;
        default:  st_d = st_q;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 6'd0;
      bits_q <= 3'd0;
      sh_q   <= 64'h0;
    end else begin
      st_q <= st_d;
      if (cs_fall_w || end_w) begin
        cnt_q <= 6'd0;
      end else if (rise_w) begin
        cnt_q <= cnt_q + 6'd1;
      end
      if (cs_fall_w) begin
        bits_q <= 3'd0;
      end else if (rise_w) begin
        bits_q <= bits_q + lane_bits(ph_lane_w);
      end
      if (rise_w) begin
        sh_q <= sh_nx_w;
      end
    end
  end

  // writes only take effect on a whole-byte frame end
  wire exec_w = cs_rise_w & (bits_q == 3'd0) &
                ((st_q == ST_WAIT) |
                 ((st_q == ST_DIN) & (din_cnt_q == dc.dlen)));
  wire cmd_end_w  = end_w & (st_q == ST_CMD);
  wire addr_end_w = end_w & (st_q == ST_ADDR);
  wire din_w      = end_w & (st_q == ST_DIN) & (din_cnt_q != 4'hf);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_q     <= 8'h00;
      addr_q    <= 32'h0;
      cont_q    <= 1'b0;
      din_cnt_q <= 4'h0;
    end else begin
      if (cmd_end_w) begin
        cmd_q <= cmd_in_w;
      end
      if (addr_end_w) begin
        addr_q <= addr_nx_w;
      end
      if (cmd_end_w || (exec_w && cmd_q == OP_SWRST)) begin
        cont_q <= 1'b0;
      end else if (end_w && st_q == ST_MODE) begin
        cont_q <= (sh_nx_w[7:4] == CONT_NIB);
      end
      if (cs_fall_w) begin
        din_cnt_q <= 4'h0;
      end else if (din_w) begin
        din_cnt_q <= din_cnt_q + 4'h1;
      end
    end
  end

  wire [7:0]  d8_w     = sh_q[7:0];
  wire [1:0]  mfld_w   = d8_w[MODE_LSB +: 2];
  wire [63:0] pwd_in_w = {sh_q[7:0], sh_q[15:8], sh_q[23:16],
                          sh_q[31:24], sh_q[39:32], sh_q[47:40],
                          sh_q[55:48], sh_q[63:56]};

  always_comb begin
    lock_d = o_lock;
    perr_d = o_perr;
    wip_d  = o_wip;
    busy_d = busy_q;
    ulk_d  = ulk_q;
    mode_d = o_mode;
    pwd_d  = pwd_q;
    pclr   = 1'b0;
    perase = 1'b0;
    vwe    = 1'b0;
    vrst   = 1'b0;
    if (busy_q != '0) begin
      busy_d = busy_q - 1'b1;
      if (busy_q == CNT_W'(1)) wip_d = 1'b0;
    end
    if (ulk_q != '0) ulk_d = ulk_q - 1'b1;
    if (init_q) lock_d = (o_mode != MODE_PWD);
    if (i_factory_init) begin
      mode_d = MODE_NONE;
      pwd_d  = PWD_SHIP;
    end
    if (exec_w) begin
      case (cmd_q)
        OP_LOCK_CLR: lock_d = 1'b0;
        OP_CLSR: begin
          perr_d = 1'b0;
          if (busy_q == '0 && ulk_q == '0) wip_d = 1'b0;
        end
        OP_SWRST: vrst = 1'b1;
        OP_PERS_PROG, OP_PERS_ERASE: begin
          wip_d = 1'b1;
          if (o_lock) begin
            pclr   = (cmd_q == OP_PERS_PROG);
            perase = (cmd_q == OP_PERS_ERASE);
            busy_d = CNT_W'(PROG_CYC);
          end else begin
            perr_d = 1'b1;
          end
        end
        OP_VOL_WR: vwe = 1'b1;
        OP_CFG_PROG: begin
          wip_d = 1'b1;
          if (o_mode == MODE_NONE && mfld_w != MODE_BAD) begin
            mode_d = mfld_w;
            busy_d = CNT_W'(PROG_CYC);
          end else begin
            perr_d = 1'b1;
          end
        end
        OP_PWD_PROG: begin
          pwd_d  = pwd_q & pwd_in_w;
          wip_d  = 1'b1;
          busy_d = CNT_W'(PROG_CYC);
        end
        OP_PWD_UNLOCK: begin
          if (o_mode == MODE_PWD && ulk_q == '0) begin
            if (pwd_in_w == pwd_q) begin
              lock_d = 1'b1;
            end else begin
              perr_d = 1'b1;
              wip_d  = 1'b1;
              ulk_d  = CNT_W'(UNLOCK_CYC);
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      init_q <= 1'b1;
      o_lock <= 1'b1;
      o_perr <= 1'b0;
      o_wip  <= 1'b0;
      busy_q <= '0;
      ulk_q  <= '0;
    end else begin
      init_q <= 1'b0;
      o_lock <= lock_d;
      o_perr <= perr_d;
      o_wip  <= wip_d;
      busy_q <= busy_d;
      ulk_q  <= ulk_d;
    end
  end

  // one-time and hidden values survive reset
  always_ff @(posedge i_clk) begin
    o_mode <= mode_d;
    pwd_q  <= pwd_d;
  end

  fspl_secmem #(
    .SECT_W (SECT_W)
  ) u_mem (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_factory    (i_factory_init),
    .i_sect       (addr_q[SECT_LSB +: SECT_W]),
    .i_pers_clr   (pclr),
    .i_pers_erase (perase),
    .i_vol_we     (vwe),
    .i_vol_val    (d8_w == BYTE_ONES),
    .i_vol_reset  (vrst),
    .o_pers       (pers_bit),
    .o_vol        (vol_bit)
  );

  // read data byte source
  wire [7:0] stat_w = 8'({7'h0, o_perr} << SR_PERR) |
                      8'({7'h0, o_wip} << SR_WIP);
  wire [7:0] src_w =
    (cmd_q == OP_RDSR)    ? stat_w :
    (cmd_q == OP_LOCK_RD) ? {7'h00, o_lock} :
    (cmd_q == OP_CFG_RD)  ? {5'h00, o_mode, 1'b1} :
    (cmd_q == OP_PERS_RD) ? {8{pers_bit}} :
    (cmd_q == OP_VOL_RD)  ? {8{vol_bit}} :
    (cmd_q == OP_PWD_RD)  ? pwd_q[{bidx_q, 3'b000} +: 8] :
    i_arr_data;
  wire       load_w = fall_w & (st_q == ST_DOUT) & (ocnt_q == 3'd0);
  wire [7:0] word_w = (ocnt_q == 3'd0) ? src_w : osh_q;
  wire [3:0] oe_w   = (st_q != ST_DOUT) ? 4'hf :
                      (dc.dl == LN_4) ? 4'h0 :
                      (dc.dl == LN_2) ? 4'hc : 4'hd;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_io      <= 4'h0;
      o_io_oe_n <= 4'hf;
      osh_q     <= 8'h00;
      ocnt_q    <= 3'd0;
      bidx_q    <= 3'd0;
    end else begin
      o_io_oe_n <= oe_w;
      if (cs_fall_w) begin
        ocnt_q <= 3'd0;
        bidx_q <= 3'd0;
      end else if (fall_w && st_q == ST_DOUT) begin
        o_io   <= out_map(word_w, dc.dl);
        osh_q  <= 8'(word_w << lane_bits(dc.dl));
        ocnt_q <= load_w ? 3'(b_edges_w - 6'd1) : ocnt_q - 3'd1;
        bidx_q <= load_w ? bidx_q + 3'd1 : bidx_q;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arr_rd      <= 1'b0;
      o_arr_addr    <= 32'h0;
      o_sect_unprot <= 1'b0;
    end else begin
      o_arr_rd      <= (addr_end_w & dc.arr) | (load_w & dc.arr);
      o_sect_unprot <= pers_bit & vol_bit;
      if (addr_end_w) begin
        o_arr_addr <= addr_nx_w;
      end else if (load_w && dc.arr) begin
        o_arr_addr <= o_arr_addr + 32'h1;
      end
    end
  end
endmodule

// ---- fspl_lock_asserts.sv ----
// port-level assertions for the sector protection lock
`timescale 1ns/100ps
module fspl_lock_asserts (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_factory_init,
  input wire logic       i_cs_n,
  input wire logic [3:0] o_io_oe_n,
  input wire logic       o_arr_rd,
  input wire logic       o_lock,
  input wire logic       o_wip,
  input wire logic       o_perr,
  input wire logic [1:0] o_mode
);
  import fspl_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_rel;
    $fell(i_rst);
  endsequence
  sequence s_err;
    $rose(o_perr);
  endsequence

  a_rst_lock_set :
    assert property (s_rel ##0 (o_mode != MODE_PWD) |-> o_lock [*2])
    else $error("lock not set after reset");
  a_rst_lock_pwd :
    assert property (s_rel ##0 (o_mode == MODE_PWD) |-> ##[1:2] !o_lock)
    else $error("lock not cleared after reset");
  a_lock_no_set :
    assert property (o_mode != MODE_PWD |-> !$rose(o_lock))
    else $error("lock set by command");
  a_err_busy :
    assert property (s_err |-> ##[0:1] o_wip)
    else $error("error without busy");
  a_err_keep_lock :
    assert property (s_err |-> $stable(o_lock))
    else $error("lock moved on error");
  a_good_unlock :
    assert property ($rose(o_lock) |-> !o_wip)
    else $error("busy on good unlock");
  a_idle_release :
    assert property (i_cs_n [*8] |-> o_io_oe_n == 4'hf)
    else $error("lanes driven while deselected");
  a_busy_no_read :
    assert property (o_wip |-> !o_arr_rd)
    else $error("array read while busy");
  a_mode_fixed :
    assert property ((o_mode == MODE_PWD || o_mode == MODE_PERS)
                     && !i_factory_init |=> $stable(o_mode))
    else $error("chosen mode changed");
endmodule

bind fspl_lock fspl_lock_asserts fspl_lock_asserts_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_factory_init(i_factory_init),
  .i_cs_n(i_cs_n), .o_io_oe_n(o_io_oe_n), .o_arr_rd(o_arr_rd),
  .o_lock(o_lock), .o_wip(o_wip), .o_perr(o_perr), .o_mode(o_mode));

// ---- fspl_host.sv ----
// host serial controller model for the flash link
`timescale 1ns/100ps
module fspl_host (
  input  wire logic [3:0] i_line,
  output logic            o_sck,
  output logic            o_cs_n,
  output logic      [3:0] o_io
);
  localparam realtime HALF = 62.5;
  // all four lanes seen at each rise, for wide reads
  logic [63:0] quad_rx;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h5;
  end
  // whole command out on io0, io1 captured at each rise
  task automatic frame(input logic [127:0] d, input int n,
                       output logic [63:0] rx);
    rx = '0;
    quad_rx = '0;
    o_cs_n <= 1'b0;
    #(HALF * 2);
    for (int i = n - 1; i >= 0; i--) begin
      o_io[0] <= d[i];
      o_io[3:1] <= ~o_io[3:1];
      #HALF o_sck <= 1'b1;
      rx = {rx[62:0], i_line[1]};
      quad_rx = {quad_rx[59:0], i_line};
      #HALF o_sck <= 1'b0;
    end
    #HALF o_cs_n <= 1'b1;
    o_io <= ~o_io;
    #(HALF * 2);
  endtask
endmodule

// ---- tb_fspl_lock.sv ----
// self-checking bench for the sector protection lock
`timescale 1ns/100ps
module tb_fspl_lock;
  import fspl_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        fac = 1'b1;
  logic        a32 = 1'b0;
  logic [7:0]  arr_data = 8'h00;
  logic [63:0] rx;
  logic [63:0] pwr;
  wire logic       sck, cs_n, arr_rd, lock, write_in_progress_flag, perr, unprot;
  wire logic [3:0] hio, io_line, dio, oe_n;
  wire logic [1:0] mode;
  wire logic [31:0] arr_addr;
  int n_fail = 0;
  int tests_run = 0;

  assign io_line = (dio & ~oe_n) | (hio & oe_n);
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) arr_data <= arr_addr[7:0] ^ 8'h5a;

  fspl_lock #(.UNLOCK_CYC(2000), .PROG_CYC(5)) fspl_lock_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_factory_init(fac), .i_addr32(a32),
    .i_sck(sck), .i_cs_n(cs_n), .i_io(io_line), .o_io(dio),
    .o_io_oe_n(oe_n), .o_arr_rd(arr_rd), .o_arr_addr(arr_addr),
    .i_arr_data(arr_data), .o_lock(lock), .o_wip(write_in_progress_flag), .o_perr(perr),
    .o_mode(mode), .o_sect_unprot(unprot));
  fspl_host fspl_host_inst (
    .i_line(io_line), .o_sck(sck), .o_cs_n(cs_n), .o_io(hio));

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmd(input logic [127:0] d, input int n);
    fspl_host_inst.frame(d, n, rx);
  endtask
  task automatic hw_reset();
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic conclude();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_boot();
    chk("mode", mode, MODE_NONE);
    chk("lock", lock, 1'b1);
  endtask
  task automatic t_reads();
    logic [127:0] c[3] = '{{8'h03, 24'h123456, 16'h0},
      {8'h03, 32'h01abcdef, 16'h0}, {8'h0b, 24'h10, 8'h0, 16'h0}};
    int n[3] = '{48, 56, 56};
    logic [15:0] e[3] = '{16'h0c0d, 16'hb5aa, 16'h4a4b};
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk) a32 <= (k == 1);
      cmd(c[k], n[k]);
      chk("read data", rx[15:0], e[k]);
    end
    @(posedge i_clk) a32 <= 1'b0;
    cmd({8'h6b, 24'h10, 8'h0, 4'h0}, 44);
    chk("quad read", fspl_host_inst.quad_rx[15:0], 16'h4a4b);
  endtask
  task automatic t_vol();
    cmd({8'he1, 24'h120000, 8'h00}, 40);
    chk("unprot", unprot, 1'b0);
    cmd(8'hf0, 8);
    cmd({8'he0, 24'h120000, 8'h00}, 40);
    chk("vol bit", rx[7:0], 8'hff);
    chk("unprot", unprot, 1'b1);
    cmd({8'ha6, 3'h0}, 11);
    chk("lock", lock, 1'b1);
    chk("lock", lock, 1'b1);
  endtask
  task automatic t_lock();
    cmd(8'ha6, 8);
    chk("lock", lock, 1'b0);
    cmd(8'hf0, 8);
    chk("lock", lock, 1'b0);
    cmd({8'ha7, 8'h00}, 16);
    chk("lock read", rx[7:0], 8'h00);
    cmd({8'he3, 24'h120000}, 32);
    cmd({8'h05, 8'h00}, 16);
    chk("status", rx[7:0], 8'h41);
    cmd(8'h30, 8);
    chk("cleared", {perr, write_in_progress_flag}, 2'b00);
    cmd({8'he9, 64'h0}, 72);
    chk("lock", lock, 1'b0);
    hw_reset();
    chk("lock", lock, 1'b1);
    cmd({8'he3, 24'h120000}, 32);
    cmd({8'h05, 8'h00}, 16);
    chk("status", rx[7:0], 8'h00);
    cmd({8'he2, 24'h120000, 8'h00}, 40);
    chk("pers bit", rx[7:0], 8'h00);
    chk("unprot", unprot, 1'b0);
    cmd(8'he4, 8);
    cmd({8'he2, 24'h120000, 8'h00}, 40);
    chk("pers erase", rx[7:0], 8'hff);
  endtask
  task automatic t_pwd();
    pwr = {<<8{64'h0123_4567_89ab_cdef}};
    cmd({8'he8, pwr}, 72);
    cmd({8'he8, 64'hffff_ffff_ffff_ffff}, 72);
    cmd({8'he7, 64'h0}, 72);
    chk("password", rx, pwr);
    chk("perr", perr, 1'b0);
    cmd({8'h2f, 8'h00}, 16);
    chk("bad mode", {mode, perr}, {MODE_NONE, 1'b1});
    cmd(8'h30, 8);
    cmd({8'h2f, 8'h02}, 16);
    chk("mode", mode, MODE_PWD);
    cmd({8'h2b, 8'h00}, 16);
    chk("mode read", rx[7:0], 8'h03);
    cmd({8'h2f, 8'h04}, 16);
    chk("mode", mode, MODE_PWD);
    cmd(8'h30, 8);
    cmd({8'he7, 64'h0}, 72);
    chk("hidden", rx === pwr, 1'b0);
    cmd({8'he8, 64'h0}, 72);
    chk("pwd prog", {perr, write_in_progress_flag}, 2'b00);
    hw_reset();
    chk("lock", lock, 1'b0);
    cmd({8'he9, 64'h1}, 72);
    chk("bad unlock", {lock, perr, write_in_progress_flag}, 3'b011);
    cmd(8'h30, 8);
    chk("guard", {perr, write_in_progress_flag}, 2'b01);
    cmd({8'h03, 24'h10, 16'h0}, 48);
    chk("busy read", rx[15:0] === 16'h4a4b, 1'b0);
    cmd({8'he9, pwr}, 72);
    chk("guard lock", lock, 1'b0);
    repeat (2000) @(posedge i_clk);
    cmd(8'h30, 8);
    chk("wip", write_in_progress_flag, 1'b0);
    cmd({8'he9, pwr}, 72);
    chk("unlock", {lock, write_in_progress_flag, perr}, 3'b100);
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    fac <= 1'b0;
    repeat (4) @(posedge i_clk);
    t_boot();
    t_reads();
    t_vol();
    t_lock();
    t_pwd();
    conclude();
  end
  initial begin
    #500_000;
    n_fail++;
    conclude();
  end
endmodule
